/* File: dv/edstx_rx_model.sv */
// Purpose: far-end differential receiver
// Assumes: frame marked by busy, first bit by word_taken
// Notes: factor of the batch given by the bench
`timescale 1ns/1ps
module edstx_rx_model
(
    // clock and frame marks
    input wire logic clock,
    input wire logic busy,
    input wire logic word_taken,
    input wire logic [3:0] factor_seen,
    // pin pairs
    input wire logic [edstx_pkg::MAX_CHANNELS-1:0] serial_p,
    input wire logic [edstx_pkg::MAX_CHANNELS-1:0] serial_n,
    // recovered word
    output logic rx_valid,
    output logic [edstx_pkg::WORD_WIDTH-1:0] rx_word
);
    logic [9:0] sh [edstx_pkg::MAX_CHANNELS];
    logic [edstx_pkg::WORD_WIDTH-1:0] w;
    int cnt = 0;
    initial rx_valid = 1'b0;
    always @(posedge clock)
    begin
        rx_valid <= 1'b0;
        if (busy === 1'b1)
        begin
            if (word_taken === 1'b1)
                cnt = 0;
            for (int c = 0; c < edstx_pkg::MAX_CHANNELS; c++)
                sh[c] = {sh[c][8:0], serial_p[c] & ~serial_n[c]};
            cnt++;
            if (cnt == factor_seen)
            begin
                w = '0;
                for (int c = 0; c < edstx_pkg::MAX_CHANNELS; c++)
                    for (int b = 0; b < cnt; b++)
                        w[c * cnt + b] = sh[c][b];
                rx_word <= w;
                rx_valid <= 1'b1;
            end
        end
    end
endmodule // edstx_rx_model

/* File: dv/edstx_tx_assertions.sv */
// Purpose: pin checks on the serializer
// Assumes: config held stable while words are in flight
// Notes: bound to edstx_tx
`timescale 1ns/1ps
module edstx_tx_assertions
(
    // clock and resets
    input wire logic clock,
    input wire logic rst,
    input wire logic data_reset,
    input wire logic clock_enable,
    // config and words
    input wire logic [3:0] factor,
    input wire logic [4:0] channel_count,
    input wire logic word_valid,
    input wire logic word_ready,
    // pins and status
    input wire logic [edstx_pkg::MAX_CHANNELS-1:0] serial_p,
    input wire logic [edstx_pkg::MAX_CHANNELS-1:0] serial_n,
    input wire logic fast_phase,
    input wire logic load_clock,
    input wire logic word_taken,
    input wire logic underrun,
    input wire logic busy,
    input wire logic rate_ok
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst || data_reset);
    sequence s_accept;
        clock_enable && word_valid && word_ready;
    endsequence
    sequence s_launch;
        ##[2:120] word_taken;
    endsequence
    AST_INVERSE: assert property (serial_n == ~serial_p) else $error("n not ~p");
    AST_LAUNCH: assert property (s_accept |-> s_launch) else $error("no launch");
    AST_TAKEN: assert property (word_taken |-> busy) else $error("taken idle");
    AST_LOAD: assert property ($changed(load_clock) == word_taken) else $error("load");
    AST_F1: assert property (busy && factor <= 4'h1 |-> !fast_phase) else $error("f1");
    AST_FIRST: assert property (word_taken && !$past(busy) && factor > 4'h1
        |-> fast_phase) else $error("phase start");
    AST_RUN: assert property (busy && $past(busy) && factor > 4'h1
        |-> fast_phase != $past(fast_phase)) else $error("phase run");
    AST_IDLE_CH: assert property (busy |-> (serial_p >> channel_count) == '0)
        else $error("spare channel");
    AST_RATE: assert property (!$past(rst) && !$past(data_reset) |-> rate_ok)
        else $error("rate");
    AST_DRESET: assert property (disable iff (rst) data_reset |-> !busy && serial_p == '0)
        else $error("data reset");
    AST_UNDERRUN: assert property ($fell(busy) |-> underrun) else $error("no underrun");
endmodule // edstx_tx_assertions

bind edstx_tx edstx_tx_assertions chk_u (.clock, .rst, .data_reset, .clock_enable,
    .factor, .channel_count, .word_valid, .word_ready, .serial_p, .serial_n,
    .fast_phase, .load_clock, .word_taken, .underrun, .busy, .rate_ok);

/* File: dv/emulated_diff_serializer_tx_test.sv */
// Purpose: self-checking bench for the serializer
// Assumes: config changed only while idle
// Notes: random words, scoreboard on recovered words
`timescale 1ns/1ps
module emulated_diff_serializer_tx_test;
    localparam int W = edstx_pkg::WORD_WIDTH;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic data_reset = 1'b0;
    logic clock_enable = 1'b1;
    logic [3:0] factor = 4'h1;
    logic [4:0] channel_count = 5'h12;
    logic standard_select = 1'b0;
    logic word_valid = 1'b0;
    logic [W-1:0] word_data = '0;
    logic [W-1:0] rx_word;
    logic [edstx_pkg::MAX_CHANNELS-1:0] serial_p, serial_n;
    logic word_ready, fast_phase, load_clock, word_taken, underrun, busy, rate_ok, rx_valid;
    logic [W-1:0] exp_q [$];
    int bad_count = 0;
    int n_tests = 0;

    always #12.5 clock = ~clock;

    edstx_tx dut_u (.clock, .rst, .data_reset, .clock_enable, .factor, .channel_count,
        .standard_select, .word_valid, .word_ready, .word_data, .serial_p, .serial_n,
        .fast_phase, .load_clock, .word_taken, .underrun, .busy, .rate_ok);
    edstx_rx_model rx_u (.clock, .busy, .word_taken,
        .factor_seen((factor > edstx_pkg::MAX_FACTOR_CODE) ? edstx_pkg::MAX_FACTOR_CODE : factor),
        .serial_p,
        .serial_n, .rx_valid, .rx_word);

    task automatic chk(string name, logic [W-1:0] exp, logic [W-1:0] got);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic report_and_stop();
        if (bad_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic send(logic [W-1:0] d);
        int n;
        int nb;
        n = 0;
        word_data <= d;
        word_valid <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (!(word_ready === 1'b1 && clock_enable === 1'b1) && n < 200);
        if (n >= 200)
            chk("accept", '0, '1);
        // bits carried: clamped channels times clamped factor
        nb = (int'(channel_count) > edstx_pkg::MAX_CHANNELS ? edstx_pkg::MAX_CHANNELS
            : int'(channel_count)) * (int'(factor) > edstx_pkg::MAX_FACTOR
            ? edstx_pkg::MAX_FACTOR : int'(factor));
        exp_q.push_back(d & ({W{1'b1}} >> (W - nb)));
    endtask

    task automatic drain();
        word_valid <= 1'b0;
        for (int i = 0; i < 300 && (exp_q.size() > 0 || busy !== 1'b0); i++)
            @(posedge clock);
        repeat (2) @(posedge clock);
        chk("queue", '0, W'(exp_q.size()));
    endtask

    task automatic pulse(logic async_kind);
        if (async_kind)
            data_reset <= 1'b1;
        else
            rst <= 1'b1;
        repeat (2) @(posedge clock);
        chk("idle", '0, W'({word_ready, busy, serial_p}));
        data_reset <= 1'b0;
        rst <= 1'b0;
        exp_q.delete();
    endtask

    // scoreboard on recovered words
    always @(posedge clock)
        if (rx_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk("spare word", '1, '0);
            else
                chk("word", exp_q.pop_front(), rx_word);
        end

    initial
    begin
        #500us;
        bad_count++;
        report_and_stop();
    end

    initial
    begin
        logic [W-1:0] d;
        void'($urandom(32'h9F30));
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        // pass 11 offers out-of-range factor and channel codes, clamped to the maxima
        for (int f = 1; f <= 11; f++)
        begin
            factor <= (f == 11) ? 4'hC : f[3:0];
            channel_count <= (f == 11) ? 5'h1F : (f == 10) ? 5'h12
                : 5'($urandom_range(18, 1));
            standard_select <= f[0];
            if (f == 5)
            begin
                clock_enable <= 1'b0;
                word_valid <= 1'b1;
                repeat (3) @(posedge clock);
                clock_enable <= 1'b1;
            end
            repeat (f >= 10 ? 10 : 3)
            begin
                d = W'({$urandom, $urandom, $urandom, $urandom, $urandom, $urandom});
                send(d);
            end
            drain();
        end
        for (int k = 1; k >= 0; k--)
        begin
            send(d);
            word_valid <= 1'b0;
            repeat (5) @(posedge clock);
            pulse(k[0]);
            send(~d);
            drain();
        end
        report_and_stop();
    end
endmodule // emulated_diff_serializer_tx_test

/* File: hdl/edstx_fifo.sv */
// Purpose: small first-in first-out buffer in front of the serializer
// Assumes: synchronous inputs, one clock
// Notes: ready and valid on both sides; full and empty are exact
`timescale 1ns/1ps
module edstx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)
(
    // clock and resets
    input wire logic clock,
    input wire logic rst,
    input wire logic data_reset,
    input wire logic clock_enable,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_index;
        logic [AW-1:0] rd_index;
        logic [AW:0] count;
    } edstx_fifo_type;

    edstx_fifo_type s;
    edstx_fifo_type next_s;
    logic push;
    logic pop;

    assign in_ready = (s.count != (AW+1)'(DEPTH));
    assign out_valid = (s.count != '0);
    assign out_data = s.mem[s.rd_index];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        next_s = s;
        if (push)
        begin
            next_s.mem[s.wr_index] = in_data;
            next_s.wr_index = (s.wr_index == AW'(DEPTH - 1)) ? '0 : s.wr_index + 1'b1;
        end
        if (pop)
        begin
            next_s.rd_index = (s.rd_index == AW'(DEPTH - 1)) ? '0 : s.rd_index + 1'b1;
        end
        if (push && !pop)
        begin
            next_s.count = s.count + 1'b1;
        end
        else if (pop && !push)
        begin
            next_s.count = s.count - 1'b1;
        end
    end

    always_ff @(posedge clock or posedge data_reset)
    begin
        if (data_reset)
        begin
            s <= '0;
        end
        else if (rst)
        begin
            s <= '0;
        end
        else if (clock_enable)
        begin
            s <= next_s;
        end
    end

endmodule // edstx_fifo

/* File: hdl/edstx_pkg.sv */
// Purpose: constants and types for the emulated differential serializer
// Assumes: one 40 MHz clock; each clock cycle is one serial bit time
// Notes: fast clock edges are modelled as successive bit cycles, one edge per bit
package edstx_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int MAX_CHANNELS = 18;
    localparam int MAX_FACTOR = 10;
    localparam int WORD_WIDTH = MAX_CHANNELS * MAX_FACTOR;
    localparam int FIFO_DEPTH = 8;
    localparam logic [3:0] MIN_FACTOR_CODE = 4'h1;
    localparam logic [3:0] MAX_FACTOR_CODE = 4'hA;
    localparam logic [4:0] MAX_CHANNEL_CODE = 5'h12;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLOCK_MHZ = 40;
    localparam int BIT_RATE_MBPS = CLOCK_MHZ;
    localparam int LVDS_MAX_MBPS = 304;
    localparam int RSDS_MAX_MBPS = 200;
    localparam logic LVDS_RATE_OK = (BIT_RATE_MBPS <= LVDS_MAX_MBPS);
    localparam logic RSDS_RATE_OK = (BIT_RATE_MBPS <= RSDS_MAX_MBPS);

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic STANDARD_EMULATED_LVDS = 1'b0;
    localparam logic STANDARD_EMULATED_RSDS = 1'b1;

    typedef enum logic [1:0] {
        EDSTX_IDLE = 2'b01,
        EDSTX_SEND = 2'b10
    } edstx_state_type;

endpackage

/* File: hdl/edstx_tx.sv */
// Purpose: parallel to serial transmitter for pseudo-differential pin pairs
// Assumes: each clock cycle is one serial bit, i.e. one fast clock edge
// Notes: parallel words are buffered; channels above the count idle low
`timescale 1ns/1ps
module edstx_tx
(
    // clock, resets, enable
    input wire logic clock,
    input wire logic rst,
    input wire logic data_reset,
    input wire logic clock_enable,
    // configuration
    input wire logic [3:0] factor,
    input wire logic [4:0] channel_count,
    input wire logic standard_select,
    // parallel words from the user's synchronization register
    input wire logic word_valid,
    output logic word_ready,
    input wire logic [edstx_pkg::WORD_WIDTH-1:0] word_data,
    // serial pin pairs
    output logic [edstx_pkg::MAX_CHANNELS-1:0] serial_p,
    output logic [edstx_pkg::MAX_CHANNELS-1:0] serial_n,
    // clock images and status
    output logic fast_phase,
    output logic load_clock,
    output logic word_taken,
    output logic underrun,
    output logic busy,
    output logic rate_ok
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        edstx_pkg::edstx_state_type state;
        logic [edstx_pkg::WORD_WIDTH-1:0] word;
        logic [3:0] bit_index;
        logic [3:0] factor_q;
        logic [4:0] channels_q;
        logic [edstx_pkg::MAX_CHANNELS-1:0] serial_p;
        logic [edstx_pkg::MAX_CHANNELS-1:0] serial_n;
        logic fast_phase;
        logic load_clock;
        logic word_taken;
        logic underrun;
        logic busy;
        logic rate_ok;
        logic fill_ready;
    } edstx_tx_type;

    localparam edstx_tx_type RESET_STATE = '{
        state: edstx_pkg::EDSTX_IDLE,
        word: '0,
        bit_index: 4'h0,
        factor_q: edstx_pkg::MIN_FACTOR_CODE,
        channels_q: 5'h00,
        serial_p: '0,
        serial_n: '1,
        fast_phase: 1'b0,
        load_clock: 1'b0,
        word_taken: 1'b0,
        underrun: 1'b0,
        busy: 1'b0,
        rate_ok: 1'b0,
        fill_ready: 1'b0
    };

    edstx_tx_type s;
    edstx_tx_type next_s;

    // ------------------------------------------------------------
    // buffer between user words and the serializer
    // ------------------------------------------------------------
    logic fifo_in_ready;
    logic fifo_valid;
    logic [edstx_pkg::WORD_WIDTH-1:0] fifo_data;
    logic drain_ready;
    logic last_bit;
    logic [3:0] factor_clamped;
    logic [4:0] channels_clamped;

    edstx_fifo #(
        .WIDTH(edstx_pkg::WORD_WIDTH),
        .DEPTH(edstx_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst(rst),
        .data_reset(data_reset),
        .clock_enable(clock_enable),
        .in_valid(word_valid && s.fill_ready),
        .in_ready(fifo_in_ready),
        .in_data(word_data),
        .out_valid(fifo_valid),
        .out_ready(drain_ready),
        .out_data(fifo_data)
    );

    // ------------------------------------------------------------
    // configuration clamp
    // ------------------------------------------------------------
    always_comb
    begin
        if (factor < edstx_pkg::MIN_FACTOR_CODE)
        begin
            factor_clamped = edstx_pkg::MIN_FACTOR_CODE;
        end
        else if (factor > edstx_pkg::MAX_FACTOR_CODE)
        begin
            factor_clamped = edstx_pkg::MAX_FACTOR_CODE;
        end
        else
        begin
            factor_clamped = factor;
        end
        if (channel_count > edstx_pkg::MAX_CHANNEL_CODE)
        begin
            channels_clamped = edstx_pkg::MAX_CHANNEL_CODE;
        end
        else
        begin
            channels_clamped = channel_count;
        end
    end

    // ------------------------------------------------------------
    // word boundary: a new word is taken after the last bit
    // ------------------------------------------------------------
    assign last_bit = (s.bit_index == (s.factor_q - 4'h1));
    assign drain_ready = (s.state == edstx_pkg::EDSTX_IDLE) || last_bit;

    always_comb
    begin
        int pos;
        logic bit_value;
        pos = 0;
        bit_value = 1'b0;
        next_s = s;
        next_s.word_taken = 1'b0;
        next_s.underrun = 1'b0;
        // ready registered, so the word_ready output is a flop; it drops for one cycle after each accepted word
        next_s.fill_ready = fifo_in_ready && !(word_valid && s.fill_ready);
        next_s.rate_ok = (standard_select == edstx_pkg::STANDARD_EMULATED_RSDS) ?
            edstx_pkg::RSDS_RATE_OK :
            edstx_pkg::LVDS_RATE_OK;
        case (s.state)
            edstx_pkg::EDSTX_IDLE:
            begin
                if (fifo_valid)
                begin
                    next_s.state = edstx_pkg::EDSTX_SEND;
                    next_s.word = fifo_data;
                    next_s.bit_index = 4'h0;
                    next_s.factor_q = factor_clamped;
                    next_s.channels_q = channels_clamped;
                    next_s.load_clock = ~s.load_clock;
                    next_s.word_taken = 1'b1;
                end
            end
            edstx_pkg::EDSTX_SEND:
            begin
                if (last_bit)
                begin
                    if (fifo_valid)
                    begin
                        next_s.word = fifo_data;
                        next_s.bit_index = 4'h0;
                        next_s.factor_q = factor_clamped;
                        next_s.channels_q = channels_clamped;
                        // toggling once per word gives period of two words
                        next_s.load_clock = ~s.load_clock;
                        next_s.word_taken = 1'b1;
                    end
                    else
                    begin
                        next_s.state = edstx_pkg::EDSTX_IDLE;
                        next_s.underrun = 1'b1;
                    end
                end
                else
                begin
                    next_s.bit_index = s.bit_index + 4'h1;
                end
            end
            default:
            begin
                next_s.state = edstx_pkg::EDSTX_IDLE;
            end
        endcase
        next_s.busy = (next_s.state == edstx_pkg::EDSTX_SEND);

        // serial bits, one per cycle per channel
        for (int c = 0; c < edstx_pkg::MAX_CHANNELS; c++)
        begin
            // channel c owns bits [c*factor +: factor], MSB first
            pos = c * int'(next_s.factor_q) + int'(next_s.factor_q) - 1
                - int'(next_s.bit_index);
            if (next_s.busy && (c < int'(next_s.channels_q)) && (pos >= 0)
                && (pos < edstx_pkg::WORD_WIDTH))
            begin
                bit_value = next_s.word[pos];
            end
            else
            begin
                bit_value = 1'b0;
            end
            next_s.serial_p[c] = bit_value;
            next_s.serial_n[c] = ~bit_value;
        end

        // fast clock image flips each bit; absent for factor one
        if (next_s.busy && (next_s.factor_q != edstx_pkg::MIN_FACTOR_CODE))
        begin
            next_s.fast_phase = ~s.fast_phase;
        end
        else
        begin
            next_s.fast_phase = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge data_reset)
    begin
        if (data_reset)
        begin
            s <= RESET_STATE;
        end
        else if (rst)
        begin
            s <= RESET_STATE;
        end
        else if (clock_enable)
        begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign word_ready = s.fill_ready;
    assign serial_p = s.serial_p;
    assign serial_n = s.serial_n;
    assign fast_phase = s.fast_phase;
    assign load_clock = s.load_clock;
    assign word_taken = s.word_taken;
    assign underrun = s.underrun;
    assign busy = s.busy;
    assign rate_ok = s.rate_ok;

endmodule // edstx_tx
